// ### src/rsfs_dev.sv
/*
  device end: enable handling, power-on clear, start-up current-limit
  timing and short-circuit qualification for a dual-rail panel supply.
  assumes analog comparators deliver rail status as asynchronous levels
  and that supply_input_ok_i falls when the supply drops near one volt.
*/
// Overview of operation
// - supply drop clears all logic including latch
// - high enable turns rail on, starts timing
// - each rail switched by own enable
// - open enable pin reads low, rail off
// - 150 ma limit 300 us, then free
// - rail short of target: drop to 25 ma
// - load beats reduced limit: latched off
// - short guard active below 60 percent target
// - activation starts 10 ms qualification count
// - low for full 10 ms: shut, latch
// - recovery within 10 ms abandons the count
// - latch cleared only by supply drop
// - host writes high code 45 ms after
// - host raises negative enable after 50 ms for high code
// - host waits 55 ms before panel load
// - host loads only output capacitors at start
// - host: load off, default code, enables low
// - host holds every enable level 1 ms
`timescale 1ns/1ps
module rsfs_dev #(
  parameter int WIN_CYC  = rsfs_pkg::LIM_WIN_CYC,
  parameter int QUAL_CYC = rsfs_pkg::SHORT_QUAL_CYC
) (
  input  wire logic               ref_clk_i,
  input  wire logic               rst_b_i,
  rsfs_if.dev                     lk,
  input  wire logic               supply_input_ok_i,
  input  wire logic               pos_at_target_i,
  input  wire logic               pos_below60_i,
  input  wire logic               neg_below60_i,
  input  wire logic               pos_overload_i,
  output logic                    positive_output_rail_on_o,
  output logic                    negative_output_rail_on_o,
  output rsfs_pkg::rsfs_lim_e     overcurrent_guard_limit_o,
  output logic [1:0]              short_circuit_guard_active_o,
  output logic                    shutdown_latched_o
);
  import rsfs_pkg::*;

  localparam int NIN    = 7;
  localparam int WIN_W  = $clog2(WIN_CYC + 1);
  localparam int QUAL_W = $clog2(QUAL_CYC + 1);

  if (WIN_CYC < 2 || QUAL_CYC < 2)
  begin : g_chk
    $error("rsfs_dev: timer counts must be at least 2");
  end

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [NIN-1:0] raw;
  logic [NIN-1:0] s1_q;
  logic [NIN-1:0] s2_q;
  logic [NIN-1:0] s3_q;
  logic [NIN-1:0] filt_q;

  assign raw = {supply_input_ok_i, pos_at_target_i, pos_below60_i,
                neg_below60_i, pos_overload_i, lk.pos_en_level,
                lk.neg_en_level};

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a level only counts once two late stages agree
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      filt_q <= '0;
    else
      for (int i = 0; i < NIN; i++)
        if (s2_q[i] == s3_q[i])
          filt_q[i] <= s3_q[i];
  end

  logic supply_ok;
  logic at_tgt;
  logic overload;
  logic [1:0] below;
  logic [1:0] en;

  assign supply_ok = filt_q[6];
  assign at_tgt    = filt_q[5];
  assign below     = {filt_q[3], filt_q[4]};
  assign overload  = filt_q[2];
  // pull-down
  // the interface resolves an open pin to low before this point
  assign en        = {filt_q[0], filt_q[1]};

  // ****************************************************************
  // shutdown latch and rail switches
  // ****************************************************************
  logic       shut_q;
  logic [1:0] rail_on_q;
  logic [1:0] short_trip;
  logic       lim_trip;
  logic [1:0] rail_on_d;

  assign rail_on_d = (supply_ok && !shut_q) ? en : 2'b00;

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rail_on_q <= 2'b00;
    else
      rail_on_q <= rail_on_d;
  end

  // supply loss acts as a reset and so beats a new trip
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      shut_q <= RST_OFF;
    else if (!supply_ok)
      shut_q <= 1'b0;
    else if (lim_trip || (|short_trip))
      shut_q <= 1'b1;
  end

  // ****************************************************************
  // start-up current limit on the positive rail
  // ****************************************************************
  rsfs_lim_e          lim_q;
  logic [WIN_W-1:0]   lim_cnt_q;

  assign lim_trip = (lim_q == LIM_REDUCED) && rail_on_q[0] && overload;

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      lim_q     <= LIM_OFF;
      lim_cnt_q <= '0;
    end
    else if (!rail_on_q[0])
    begin
      lim_q     <= LIM_OFF;
      lim_cnt_q <= '0;
    end
    else
    begin
      case (lim_q)
        LIM_OFF:
        begin
          lim_q     <= LIM_START;
          lim_cnt_q <= '0;
        end
        LIM_START:
        begin
          lim_cnt_q <= lim_cnt_q + 1'b1;
          if (lim_cnt_q == WIN_W'(WIN_CYC - 1))
            lim_q <= at_tgt ? LIM_FREE : LIM_REDUCED;
        end
        LIM_REDUCED:
        begin
          if (at_tgt)
            lim_q <= LIM_FREE;
        end
        default:
          lim_q <= LIM_FREE;
      endcase
    end
  end

  // ****************************************************************
  // short-circuit qualification, one counter per rail
  // ****************************************************************
  logic [QUAL_W-1:0] short_cnt_q [2];
  logic [1:0]        short_act;

  assign short_act = below & rail_on_q;

  always_comb
  begin
    for (int r = 0; r < 2; r++)
      short_trip[r] = short_act[r] &&
                      (short_cnt_q[r] == QUAL_W'(QUAL_CYC - 1));
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      short_cnt_q[0] <= '0;
      short_cnt_q[1] <= '0;
    end
    else
      for (int r = 0; r < 2; r++)
        if (!short_act[r])
          short_cnt_q[r] <= '0;
        else if (!short_trip[r])
          short_cnt_q[r] <= short_cnt_q[r] + 1'b1;
  end

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      positive_output_rail_on_o    <= 1'b0;
      negative_output_rail_on_o    <= 1'b0;
      overcurrent_guard_limit_o    <= LIM_OFF;
      short_circuit_guard_active_o <= 2'b00;
      shutdown_latched_o           <= 1'b0;
    end
    else
    begin
      positive_output_rail_on_o    <= rail_on_q[0];
      negative_output_rail_on_o    <= rail_on_q[1];
      overcurrent_guard_limit_o    <= lim_q;
      short_circuit_guard_active_o <= short_act;
      shutdown_latched_o           <= shut_q;
    end
  end

endmodule

// ### src/rsfs_pkg.sv
/*
  constants and types shared by the rail sequencer device end and the
  host end; assumes a single 20 mhz reference clock on both ends
*/
package rsfs_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_HZ          = 20_000_000;
  localparam int CYC_PER_US      = CLK_HZ / 1_000_000;
  localparam int CYC_PER_MS      = CLK_HZ / 1_000;
  localparam int LIM_WIN_US      = 300;
  localparam int SHORT_QUAL_MS   = 10;
  localparam int HV_CODE_DLY_MS  = 45;
  localparam int NEG_EN_DLY_MS   = 50;
  localparam int LOAD_DLY_MS     = 55;
  localparam int EN_HOLD_MS      = 1;
  localparam int LIM_WIN_CYC     = LIM_WIN_US * CYC_PER_US;
  localparam int SHORT_QUAL_CYC  = SHORT_QUAL_MS * CYC_PER_MS;
  localparam int HV_CODE_DLY_CYC = HV_CODE_DLY_MS * CYC_PER_MS;
  localparam int NEG_EN_DLY_CYC  = NEG_EN_DLY_MS * CYC_PER_MS;
  localparam int LOAD_DLY_CYC    = LOAD_DLY_MS * CYC_PER_MS;
  localparam int EN_HOLD_CYC     = EN_HOLD_MS * CYC_PER_MS;

  // ****************************************************************
  // codes, widths, reset values
  // ****************************************************************
  localparam int       SYNC_STAGES  = 3;
  localparam int       CODE_W       = 5;
  localparam logic [4:0] DEFAULT_CODE = 5'h0a;
  localparam logic [4:0] HV_CODE_MIN  = 5'h0f;
  localparam logic       RST_OFF      = 1'b0;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    LIM_OFF,
    LIM_START,
    LIM_FREE,
    LIM_REDUCED
  } rsfs_lim_e;

  typedef enum logic [2:0] {
    HST_GAP,
    HST_OFF,
    HST_RAMP,
    HST_ON,
    HST_CODE_OFF,
    HST_DROP
  } rsfs_hst_e;

endpackage

// ### src/rsfs_if.sv
/*
  enable pins between host and device; the host drives each pin with an
  output enable, the device sees the pin level with its pull-down applied
*/
`timescale 1ns/1ps
interface rsfs_if;
  logic pos_rail_enable_pin;
  logic pos_rail_enable_pin_oe;
  logic neg_rail_enable_pin;
  logic neg_rail_enable_pin_oe;
  logic pos_en_level;
  logic neg_en_level;

  // undriven pin reads low through the internal pull-down
  assign pos_en_level = pos_rail_enable_pin_oe & pos_rail_enable_pin;
  assign neg_en_level = neg_rail_enable_pin_oe & neg_rail_enable_pin;

  modport host (
    output pos_rail_enable_pin,
    output pos_rail_enable_pin_oe,
    output neg_rail_enable_pin,
    output neg_rail_enable_pin_oe
  );

  modport dev (
    input pos_en_level,
    input neg_en_level
  );
endinterface

// ### src/rsfs_host.sv
/*
  host end: drives both rail enables and asks for output-voltage code
  writes in the required start-up and shutdown order; assumes a serial
  bus writer outside takes code_wr_o and code_o
*/
`timescale 1ns/1ps
module rsfs_host #(
  parameter int CODE_CYC = rsfs_pkg::HV_CODE_DLY_CYC,
  parameter int NEG_CYC  = rsfs_pkg::NEG_EN_DLY_CYC,
  parameter int LOAD_CYC = rsfs_pkg::LOAD_DLY_CYC,
  parameter int HOLD_CYC = rsfs_pkg::EN_HOLD_CYC
) (
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_b_i,
  rsfs_if.host                             lk,
  input  wire logic                        power_up_i,
  input  wire logic [rsfs_pkg::CODE_W-1:0] target_code_i,
  output logic                             code_wr_o,
  output logic [rsfs_pkg::CODE_W-1:0]      code_o,
  output logic                             load_en_o,
  output logic                             busy_o
);
  import rsfs_pkg::*;

  localparam int TW = $clog2(LOAD_CYC + 1);

  // one counter sized for the load wait times every wait, hold included
  if (HOLD_CYC < 1 || CODE_CYC < 1 || CODE_CYC >= NEG_CYC ||
      NEG_CYC >= LOAD_CYC || HOLD_CYC > LOAD_CYC)
  begin : g_chk
    $error("rsfs_host: need 1 <= hold <= load, code < neg < load");
  end

  rsfs_hst_e   st_q;
  logic [TW-1:0] t_q;
  logic        hv_q;
  logic        pos_q;
  logic        neg_q;

  assign lk.pos_rail_enable_pin    = pos_q;
  assign lk.neg_rail_enable_pin    = neg_q;
  assign lk.pos_rail_enable_pin_oe = 1'b1;
  assign lk.neg_rail_enable_pin_oe = 1'b1;

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_q      <= HST_GAP;
      t_q       <= '0;
      hv_q      <= 1'b0;
      pos_q     <= 1'b0;
      neg_q     <= 1'b0;
      code_wr_o <= 1'b0;
      code_o    <= DEFAULT_CODE;
      load_en_o <= 1'b0;
      busy_o    <= 1'b1;
    end
    else
    begin
      code_wr_o <= 1'b0;
      case (st_q)
        HST_GAP:
        begin
          t_q <= t_q + 1'b1;
          if (t_q == TW'(HOLD_CYC - 1))
          begin
            st_q   <= HST_OFF;
            busy_o <= 1'b0;
          end
        end
        HST_OFF:
        begin
          if (power_up_i)
          begin
            st_q   <= HST_RAMP;
            t_q    <= '0;
            busy_o <= 1'b1;
            hv_q   <= target_code_i >= HV_CODE_MIN;
            pos_q  <= 1'b1;
            // low codes start both rails together
            neg_q  <= target_code_i < HV_CODE_MIN;
            code_o <= target_code_i;
          end
        end
        HST_RAMP:
        begin
          t_q <= t_q + 1'b1;
          if (hv_q && t_q == TW'(CODE_CYC - 1))
            code_wr_o <= 1'b1;
          if (hv_q && t_q == TW'(NEG_CYC - 1))
            neg_q <= 1'b1;
          if (t_q == TW'(LOAD_CYC - 1))
          begin
            st_q      <= HST_ON;
            load_en_o <= 1'b1;
            busy_o    <= 1'b0;
          end
        end
        HST_ON:
        begin
          if (!power_up_i)
          begin
            st_q      <= HST_CODE_OFF;
            load_en_o <= 1'b0;
            busy_o    <= 1'b1;
          end
        end
        HST_CODE_OFF:
        begin
          st_q      <= HST_DROP;
          code_o    <= DEFAULT_CODE;
          code_wr_o <= 1'b1;
        end
        default:
        begin
          st_q  <= HST_GAP;
          t_q   <= '0;
          pos_q <= 1'b0;
          neg_q <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ### sim/rsfs_link_monitor.sv
/*
  wire checks on the enable link between host end and device end;
  expects the bench to pass in the link signals, clock and reset
*/
`timescale 1ns/1ps
module rsfs_link_monitor #(
  parameter int NEG_CYC  = 40,
  parameter int HOLD_CYC = 10
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic pos_rail_enable_pin,
  input wire logic pos_rail_enable_pin_oe,
  input wire logic neg_rail_enable_pin,
  input wire logic neg_rail_enable_pin_oe,
  input wire logic pos_en_level,
  input wire logic neg_en_level
);
  // ********
  // level age counters, saturating so they never wrap
  // ********
  int pos_age_q;
  int neg_age_q;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
    if (!rst_b_i)
      pos_age_q <= 0;
    else if ($changed(pos_rail_enable_pin))
      pos_age_q <= 0;
    else if (pos_age_q < 1000)
      pos_age_q <= pos_age_q + 1;

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
    if (!rst_b_i)
      neg_age_q <= 0;
    else if ($changed(neg_rail_enable_pin))
      neg_age_q <= 0;
    else if (neg_age_q < 1000)
      neg_age_q <= neg_age_q + 1;

  // ********
  // properties
  // ********
  oe_driven_a: assert property (
    pos_rail_enable_pin_oe && neg_rail_enable_pin_oe)
    else $error("enable pin left undriven");
  neg_delay_a: assert property (
    $rose(neg_rail_enable_pin) |->
      $rose(pos_rail_enable_pin) || pos_age_q == NEG_CYC - 1)
    else $error("negative enable off its delay");
  pos_hold_a: assert property (
    $changed(pos_rail_enable_pin) |-> pos_age_q >= HOLD_CYC - 1)
    else $error("positive enable level too short");
  neg_hold_a: assert property (
    $changed(neg_rail_enable_pin) |-> neg_age_q >= HOLD_CYC - 1)
    else $error("negative enable level too short");
  neg_needs_pos_a: assert property (
    neg_rail_enable_pin |-> pos_rail_enable_pin)
    else $error("negative enable without positive");
  neg_bound_a: assert property (
    $rose(pos_rail_enable_pin) |-> ##[0:NEG_CYC] neg_rail_enable_pin)
    else $error("negative enable late");
  fall_together_a: assert property (
    $fell(pos_rail_enable_pin) |-> $fell(neg_rail_enable_pin))
    else $error("enables not dropped together");
  neg_drop_a: assert property (
    $fell(neg_rail_enable_pin) |-> $fell(pos_rail_enable_pin))
    else $error("negative enable dropped alone");
endmodule

// ### sim/rail_start_fault_sequencer_tb.sv
/*
  bench: host end drives a device end over one link, a second device
  end sees a link driven here; assumes the short timers set below
*/
`timescale 1ns/1ps
module rail_start_fault_sequencer_tb;
  import rsfs_pkg::*;
  localparam int WIN  = 20;
  localparam int QUAL = 40;
  localparam int NEG  = 40;
  localparam int LOAD = 50;
  localparam int HOLD = 10;

  logic       clk, rst_b, pwr, sup_ok, at_tgt, ovl;
  logic       wr, load, busy, r1p, r1n, r2p, r2n, latch;
  logic [4:0] tcode, code, wr_code;
  logic [1:0] b60, sc_act;
  rsfs_lim_e  lim;
  int         failures, checks_done, n;
  int         t_pos, t_neg, t_wr, t_load;

  rsfs_if lk_if ();
  rsfs_if lk2_if ();

  rsfs_host #(.CODE_CYC(30), .NEG_CYC(NEG), .LOAD_CYC(LOAD),
    .HOLD_CYC(HOLD)) rsfs_host_i (.ref_clk_i(clk), .rst_b_i(rst_b),
    .lk(lk_if), .power_up_i(pwr), .target_code_i(tcode),
    .code_wr_o(wr), .code_o(code), .load_en_o(load), .busy_o(busy));
  rsfs_dev #(.WIN_CYC(WIN), .QUAL_CYC(QUAL)) rsfs_dev_i (.ref_clk_i(clk),
    .rst_b_i(rst_b), .lk(lk_if), .supply_input_ok_i(sup_ok),
    .pos_at_target_i(at_tgt), .pos_below60_i(b60[0]),
    .neg_below60_i(b60[1]), .pos_overload_i(ovl),
    .positive_output_rail_on_o(r1p), .negative_output_rail_on_o(r1n),
    .overcurrent_guard_limit_o(), .short_circuit_guard_active_o(),
    .shutdown_latched_o());
  rsfs_dev #(.WIN_CYC(WIN), .QUAL_CYC(QUAL)) rsfs_dev_i2 (.ref_clk_i(clk),
    .rst_b_i(rst_b), .lk(lk2_if), .supply_input_ok_i(sup_ok),
    .pos_at_target_i(at_tgt), .pos_below60_i(b60[0]),
    .neg_below60_i(b60[1]), .pos_overload_i(ovl),
    .positive_output_rail_on_o(r2p), .negative_output_rail_on_o(r2n),
    .overcurrent_guard_limit_o(lim), .short_circuit_guard_active_o(sc_act),
    .shutdown_latched_o(latch));
  rsfs_link_monitor #(.NEG_CYC(NEG), .HOLD_CYC(HOLD)) rsfs_mon_i (
    .ref_clk_i(clk), .rst_b_i(rst_b),
    .pos_rail_enable_pin(lk_if.pos_rail_enable_pin),
    .pos_rail_enable_pin_oe(lk_if.pos_rail_enable_pin_oe),
    .neg_rail_enable_pin(lk_if.neg_rail_enable_pin),
    .neg_rail_enable_pin_oe(lk_if.neg_rail_enable_pin_oe),
    .pos_en_level(lk_if.pos_en_level), .neg_en_level(lk_if.neg_en_level));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ********
  // helpers
  // ********
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  // cycle index of the first change of each enable pin and of load, and of the first write pulse
  task automatic track(input int len);
    logic p0, n0, l0;
    p0 = lk_if.pos_rail_enable_pin;
    n0 = lk_if.neg_rail_enable_pin;
    l0 = load;
    t_pos = -1;
    t_neg = -1;
    t_wr = -1;
    t_load = -1;
    for (int k = 0; k < len; k++)
    begin
      cyc(1);
      if (t_pos < 0 && lk_if.pos_rail_enable_pin !== p0) t_pos = k;
      if (t_neg < 0 && lk_if.neg_rail_enable_pin !== n0) t_neg = k;
      if (t_load < 0 && load !== l0) t_load = k;
      if (t_wr < 0 && wr === 1'b1)
      begin
        t_wr = k;
        wr_code = code;
      end
    end
  endtask

  // bounded wait for a limit state, then its length in cycles
  task automatic span(input rsfs_lim_e v, output int len);
    int w;
    len = 0;
    for (w = 0; w < 60 && lim !== v; w++)
      cyc(1);
    if (w == 60)
    begin
      failures++;
      tally_and_finish();
    end
    while (lim === v && len < 100)
    begin
      cyc(1);
      len++;
    end
  endtask

  task automatic idle_wait;
    for (int k = 0; k < 200 && busy !== 1'b0; k++)
      cyc(1);
    if (busy !== 1'b0)
    begin
      failures++;
      tally_and_finish();
    end
  endtask

  // ********
  // sequence
  // ********
  initial
  begin
    failures = 0;
    checks_done = 0;
    {pwr, ovl, b60, rst_b} = '0;
    {sup_ok, at_tgt} = 2'b11;
    tcode = DEFAULT_CODE;
    lk2_if.pos_rail_enable_pin = 1'b1;
    lk2_if.neg_rail_enable_pin = 1'b1;
    lk2_if.pos_rail_enable_pin_oe = 1'b0;
    lk2_if.neg_rail_enable_pin_oe = 1'b0;
    cyc(2);
    rst_b = 1'b1;
    idle_wait();
    tcode = HV_CODE_MIN;
    pwr = 1'b1;
    track(LOAD + 20);
    check(t_wr - t_pos, 30);
    check(wr_code, HV_CODE_MIN);
    check(t_neg - t_pos, NEG);
    check(t_load - t_pos, LOAD);
    check({r1p, r1n}, 2'b11);
    $display("high start done");
    pwr = 1'b0;
    track(10);
    check(t_wr - t_load, 1);
    check(wr_code, DEFAULT_CODE);
    check(t_pos - t_load, 2);
    idle_wait();
    check({r1p, r1n}, 2'b00);
    tcode = DEFAULT_CODE;
    pwr = 1'b1;
    track(LOAD + 20);
    check(t_neg, t_pos);
    check(t_wr, -1);
    pwr = 1'b0;
    cyc(5);
    idle_wait();
    $display("low start done");
    cyc(HOLD + 10);
    check({r2p, r2n}, 2'b00);
    lk2_if.pos_rail_enable_pin_oe = 1'b1;
    span(LIM_START, n);
    check(n, WIN);
    check(lim, LIM_FREE);
    check({r2p, r2n}, 2'b10);
    lk2_if.pos_rail_enable_pin = 1'b0;
    lk2_if.neg_rail_enable_pin_oe = 1'b1;
    // bench keeps each level past the hold time
    cyc(HOLD + 10);
    check({r2p, r2n, lim}, {2'b01, LIM_OFF});
    lk2_if.neg_rail_enable_pin = 1'b0;
    $display("enable test done");
    at_tgt = 1'b0;
    lk2_if.pos_rail_enable_pin = 1'b1;
    span(LIM_START, n);
    check(lim, LIM_REDUCED);
    at_tgt = 1'b1;
    cyc(10);
    check(lim, LIM_FREE);
    lk2_if.pos_rail_enable_pin = 1'b0;
    cyc(HOLD + 5);
    at_tgt = 1'b0;
    lk2_if.pos_rail_enable_pin = 1'b1;
    span(LIM_START, n);
    ovl = 1'b1;
    cyc(10);
    check({latch, r2p}, 2'b10);
    ovl = 1'b0;
    at_tgt = 1'b1;
    lk2_if.pos_rail_enable_pin = 1'b0;
    cyc(HOLD + 5);
    lk2_if.pos_rail_enable_pin = 1'b1;
    cyc(HOLD + 5);
    check({latch, r2p}, 2'b10);
    sup_ok = 1'b0;
    cyc(10);
    check(latch, 1'b0);
    sup_ok = 1'b1;
    cyc(HOLD + 10);
    check(r2p, 1'b1);
    $display("current limit test done");
    lk2_if.neg_rail_enable_pin = 1'b1;
    cyc(HOLD + 10);
    b60 = 2'b01;
    cyc(QUAL - 10);
    check(sc_act, 2'b01);
    b60 = 2'b00;
    cyc(10);
    check({latch, r2p, r2n}, 3'b011);
    b60 = 2'b10;
    cyc(20);
    check({sc_act, latch}, 3'b100);
    cyc(QUAL - 5);
    check({latch, r2p, r2n}, 3'b100);
    b60 = 2'b00;
    $display("short circuit test done");
    tally_and_finish();
  end
endmodule
